// file: design/scs_pkg.sv
// Package of the serial-interface control and status register block.
// Assumes a single system clock; all users refer to names as scs_pkg::name.
package scs_pkg;

    localparam int ADDR_W = 15;
    localparam int INSTR_BITS = 16;

    // Register offsets
    localparam logic [14:0] OFS_LOOP_LEN = 15'h000E;
    localparam logic [14:0] OFS_XFER_CTRL = 15'h000F;
    localparam logic [14:0] OFS_LINK_CFG3 = 15'h0010;
    localparam logic [14:0] OFS_ERR_FLAGS = 15'h0011;
    localparam logic [14:0] OFS_CHAN_MODE = 15'h0020;

    // Reset values
    localparam logic [7:0] RST_LOOP_LEN = 8'h00;
    localparam logic [7:0] RST_XFER_CTRL = 8'h00;
    localparam logic [7:0] RST_LINK_CFG3 = 8'h23;
    localparam logic [7:0] RST_ERR_FLAGS = 8'h00;
    localparam logic [7:0] RST_CHAN_MODE = 8'hFF;

    // Field positions
    localparam int BIT_HOLD_LOOP = 2;
    localparam int BIT_NOT_READY = 7;
    localparam int BIT_CLK_CNT = 4;
    localparam int BIT_CRC_ERR = 3;
    localparam int BIT_PARTIAL = 1;
    localparam int BIT_STRICT = 5;
    localparam int CRC_EN_HI = 7;
    localparam int CRC_EN_LO = 6;
    localparam int MODE_HI = 3;
    localparam int MODE_LO = 2;
    localparam int CRCB_HI = 1;
    localparam int CRCB_LO = 0;

    // Field codes and write masks
    localparam logic [1:0] CRC_EN_ON = 2'h1;
    localparam logic [1:0] CRCB_ON = 2'h2;
    localparam logic [1:0] CRCB_OFF = 2'h3;
    localparam logic [1:0] CHAN_NORMAL = 2'h0;
    localparam logic [7:0] XFER_WR_MASK = 8'h04;
    localparam logic [7:0] CFG3_WR_MASK = 8'hC3;
    localparam logic [7:0] ERR_W1C_MASK = 8'h9A;

    // Checksum byte
    localparam logic [7:0] CRC_POLY = 8'h07;
    localparam logic [7:0] CRC_INIT = 8'h00;

    // Timing
    localparam int CLK_PERIOD_NS = 5;
    localparam int INIT_TIME_NS = 1000;
    localparam int INIT_CYCLES = (INIT_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

    typedef enum logic [2:0] {
        PH_IDLE,
        PH_INSTR,
        PH_DATA,
        PH_CRC,
        PH_SKIP
    } scs_phase_e;

    typedef struct packed {
        logic [14:0] addr;
        logic [7:0] data;
    } scs_wr_s;

    typedef struct packed {
        logic sclk_m;
        logic sclk_s;
        logic sclk_p;
        logic sel_m;
        logic sel_s;
        logic sel_p;
        logic sdi_m;
        logic sdi_s;
        scs_phase_e phase;
        logic [3:0] bit_cnt;
        logic [15:0] shift;
        logic is_read;
        logic got_data;
        logic [14:0] addr;
        logic [14:0] start_addr;
        logic [7:0] loop_cnt;
        logic [7:0] held_byte;
        logic [7:0] sdo_sh;
        logic sdo;
        logic sdo_oe;
        scs_wr_s pend;
        logic pend_v;
        logic [7:0] init_cnt;
        logic ready;
        logic crc_active;
        logic [3:0] pd;
        logic [7:0] loop_len;
        logic [7:0] xfer;
        logic [7:0] cfg3;
        logic [7:0] errs;
        logic [7:0] chan;
    } scs_state_s;

endpackage : scs_pkg

// file: design/scs_skid_buf.sv
// Two-entry buffer with valid and ready on both sides.
// Assumes one clock; the filling side holds its word until in_ready.
`timescale 1ns/1ps
module scs_skid_buf #(
    parameter int WIDTH = 23,
    parameter int DEPTH = 2
) (
    input wire logic clk_sys,
    input wire logic rst,
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [WIDTH-1:0] in_data,
    output logic out_valid,
    input wire logic out_ready,
    output logic [WIDTH-1:0] out_data
);
    localparam int PW = $clog2(DEPTH);

    typedef struct packed {
        logic [DEPTH-1:0][WIDTH-1:0] mem;
        logic [PW-1:0] head;
        logic [PW-1:0] tail;
        logic [PW:0] cnt;
    } scs_buf_s;

    scs_buf_s q;
    scs_buf_s d;
    logic push;
    logic pop;

    assign in_ready = (q.cnt != DEPTH[PW:0]);
    assign out_valid = (q.cnt != '0);
    assign out_data = q.mem[q.head];
    assign push = in_valid && in_ready;
    assign pop = out_valid && out_ready;

    always_comb begin
        d = q;
        if (push) begin
            d.mem[q.tail] = in_data;
            d.tail = q.tail + 1'b1;
        end
        if (pop) begin
            d.head = q.head + 1'b1;
        end
        d.cnt = q.cnt + {{PW{1'b0}}, push} - {{PW{1'b0}}, pop};
    end

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            q <= '0;
        end else begin
            q <= d;
        end
    end

endmodule : scs_skid_buf

// file: design/scs_regs_top.sv
// Serial-link slave with the loop, transfer, link-config and error-flag registers.
// Assumes sclk, select_n and sdi come from pins; mode-0 link, MSB first.
// Operation
// [R01] Nonzero loop length returns address to start after that many bytes, max 255.
// [R02] Zero loop length disables loop-back; address wraps at register-space limits.
// [R03] Loop counter clears on select rise unless the hold bit is set.
// [R04] Checksum turns on only with 01 in enable field and inverse in inverted field.
// [R05] Inverted field 10 means on, 11 means off; resets to off.
// [R06] Strict access bit is read-only and always one.
// [R07] Error flags stay set until a one is written to their bit.
// [R08] Frame started before initialization ends sets the not-ready flag.
// [R09] Frame with wrong number of clock edges sets the clock count flag.
// [R10] With checksum on, missing or wrong checksum byte sets the checksum flag.
// [R11] Access ending before all data bytes arrive sets the partial access flag.
// [R12] Active interface mode field is read-only and reads zero.
// [R13] Channel mode register at 0x20 resets to 0xFF, two bits per channel.
// [R14] Streaming steps the address by one, up or down per direction bit.
// [R15] Streaming advances address per byte; one-shot mode keeps the address.
// [R16] Channel mode 00 is normal; other codes are power-down.
// [R17] Non-complementary checksum fields leave checking off.
`timescale 1ns/1ps
module scs_regs_top #(
    parameter int INIT_CYCLES = scs_pkg::INIT_CYCLES
) (
    input wire logic clk_sys,
    input wire logic rst,
    input wire logic sclk,
    input wire logic select_n,
    input wire logic sdi,
    input wire logic address_direction_up,
    input wire logic one_shot_access_mode,
    output logic sdo,
    output logic sdo_oe,
    output logic [7:0] channel_output_mode,
    output logic [3:0] channel_power_down,
    output logic checksum_active,
    output logic init_done
);
    scs_pkg::scs_state_s q;
    scs_pkg::scs_state_s d;

    logic rise;
    logic fall;
    logic sel_fall;
    logic sel_rise;
    logic byte_done;
    logic rd_fetch;
    logic cfg_ok;
    logic step_wrap;
    logic [7:0] set_v;
    logic [7:0] rx_byte;
    logic buf_in_ready;
    logic buf_out_valid;
    scs_pkg::scs_wr_s buf_out;

    function automatic logic [7:0] crc8(input logic [7:0] b);
        logic [7:0] c;
        c = scs_pkg::CRC_INIT ^ b;
        for (int i = 0; i < 8; i++) begin
            c = c[7] ? ((c << 1) ^ scs_pkg::CRC_POLY) : (c << 1);
        end
        return c;
    endfunction : crc8

    // Next {loop count, address} after one data byte
    function automatic logic [22:0] step(input logic [14:0] a, input logic [14:0] st,
            input logic [7:0] cnt, input logic [7:0] len, input logic up, input logic one);
        logic [7:0] c1;
        logic [14:0] a1;
        c1 = cnt + 8'h01;
        a1 = up ? (a + 15'h0001) : (a - 15'h0001);
        if (one) begin
            return {cnt, a};
        end else if ((len != 8'h00) && (c1 == len)) begin
            return {8'h00, st};
        end
        return {c1, a1};
    endfunction : step

    function automatic logic [7:0] reg_read(input logic [14:0] a, input scs_pkg::scs_state_s s);
        if (a == scs_pkg::OFS_LOOP_LEN) begin
            return s.loop_len;
        end else if (a == scs_pkg::OFS_XFER_CTRL) begin
            return s.xfer;
        end else if (a == scs_pkg::OFS_LINK_CFG3) begin
            return s.cfg3;
        end else if (a == scs_pkg::OFS_ERR_FLAGS) begin
            return s.errs;
        end else if (a == scs_pkg::OFS_CHAN_MODE) begin
            return s.chan;
        end
        return 8'h00;
    endfunction : reg_read

    assign rise = q.sclk_s && !q.sclk_p && !q.sel_s;
    assign fall = !q.sclk_s && q.sclk_p && !q.sel_s;
    assign sel_fall = !q.sel_s && q.sel_p;
    assign sel_rise = q.sel_s && !q.sel_p;
    assign byte_done = rise && (q.bit_cnt[2:0] == 3'h7)
        && ((q.phase == scs_pkg::PH_DATA) || (q.phase == scs_pkg::PH_CRC));
    assign rx_byte = {q.shift[6:0], q.sdi_s};
    // [R04] [R05] both fields agree
    assign cfg_ok = (q.cfg3[scs_pkg::CRC_EN_HI:scs_pkg::CRC_EN_LO] == scs_pkg::CRC_EN_ON)
        && (q.cfg3[scs_pkg::CRCB_HI:scs_pkg::CRCB_LO] == scs_pkg::CRCB_ON);
    assign step_wrap = byte_done && (q.phase == scs_pkg::PH_DATA) && !one_shot_access_mode
        && (q.is_read || !q.crc_active)
        && (q.loop_len != 8'h00) && ((q.loop_cnt + 8'h01) == q.loop_len);
    // Register writes stall while a read byte is fetched
    assign rd_fetch = q.is_read && byte_done;

    scs_skid_buf #(
        .WIDTH($bits(scs_pkg::scs_wr_s)),
        .DEPTH(2)
    ) u_wr_buf (
        .clk_sys(clk_sys),
        .rst(rst),
        .in_valid(q.pend_v),
        .in_ready(buf_in_ready),
        .in_data(q.pend),
        .out_valid(buf_out_valid),
        .out_ready(!rd_fetch),
        .out_data(buf_out)
    );

    always_comb begin
        d = q;
        set_v = 8'h00;
        d.sclk_m = sclk;
        d.sclk_s = q.sclk_m;
        d.sclk_p = q.sclk_s;
        d.sel_m = select_n;
        d.sel_s = q.sel_m;
        d.sel_p = q.sel_s;
        d.sdi_m = sdi;
        d.sdi_s = q.sdi_m;
        if (!q.ready) begin
            d.init_cnt = q.init_cnt + 8'h01;
            d.ready = (q.init_cnt == 8'(INIT_CYCLES - 1));
        end
        // [R17] mismatched fields keep checking off
        d.crc_active = cfg_ok && (q.cfg3[scs_pkg::CRCB_HI:scs_pkg::CRCB_LO]
            == ~q.cfg3[scs_pkg::CRC_EN_HI:scs_pkg::CRC_EN_LO]);
        // [R16] channel mode decode
        for (int ch = 0; ch < 4; ch++) begin
            d.pd[ch] = (q.chan[2*ch +: 2] != scs_pkg::CHAN_NORMAL);
        end
        if (q.pend_v && buf_in_ready) begin
            d.pend_v = 1'b0;
        end
        if (buf_out_valid && !rd_fetch) begin
            if (buf_out.addr == scs_pkg::OFS_LOOP_LEN) begin
                d.loop_len = buf_out.data;
            end else if (buf_out.addr == scs_pkg::OFS_XFER_CTRL) begin
                d.xfer = buf_out.data & scs_pkg::XFER_WR_MASK;
            end else if (buf_out.addr == scs_pkg::OFS_LINK_CFG3) begin
                // [R06] [R12] read-only bits untouched
                d.cfg3 = (q.cfg3 & ~scs_pkg::CFG3_WR_MASK)
                    | (buf_out.data & scs_pkg::CFG3_WR_MASK);
            end else if (buf_out.addr == scs_pkg::OFS_ERR_FLAGS) begin
                // [R07] write one to clear
                d.errs = q.errs & ~(buf_out.data & scs_pkg::ERR_W1C_MASK);
            end else if (buf_out.addr == scs_pkg::OFS_CHAN_MODE) begin
                d.chan = buf_out.data;
            end
        end
        if (sel_fall) begin
            d.bit_cnt = 4'h0;
            d.got_data = 1'b0;
            d.sdo_oe = 1'b0;
            if (q.ready) begin
                d.phase = scs_pkg::PH_INSTR;
            end else begin
                // [R08] early frame
                d.phase = scs_pkg::PH_SKIP;
                set_v[scs_pkg::BIT_NOT_READY] = 1'b1;
            end
        end else if (sel_rise) begin
            if (q.phase != scs_pkg::PH_IDLE && q.phase != scs_pkg::PH_SKIP) begin
                // [R09] partial byte or instruction
                if (q.phase == scs_pkg::PH_INSTR || q.bit_cnt[2:0] != 3'h0) begin
                    set_v[scs_pkg::BIT_CLK_CNT] = 1'b1;
                end
                // [R11] no complete data byte
                if (q.phase != scs_pkg::PH_INSTR && !q.got_data) begin
                    set_v[scs_pkg::BIT_PARTIAL] = 1'b1;
                end
                // [R10] checksum byte omitted
                if (q.phase == scs_pkg::PH_CRC && q.bit_cnt[2:0] == 3'h0) begin
                    set_v[scs_pkg::BIT_CRC_ERR] = 1'b1;
                end
            end
            d.phase = scs_pkg::PH_IDLE;
            d.sdo_oe = 1'b0;
            // [R03] loop counter clear unless held
            if (!q.xfer[scs_pkg::BIT_HOLD_LOOP]) begin
                d.loop_cnt = 8'h00;
            end
        end else if (rise) begin
            d.shift = {q.shift[14:0], q.sdi_s};
            case (q.phase)
                scs_pkg::PH_INSTR: begin
                    d.bit_cnt = q.bit_cnt + 4'h1;
                    if (q.bit_cnt == 4'(scs_pkg::INSTR_BITS - 1)) begin
                        d.is_read = q.shift[14];
                        d.addr = {q.shift[13:0], q.sdi_s};
                        d.start_addr = {q.shift[13:0], q.sdi_s};
                        d.phase = scs_pkg::PH_DATA;
                        d.bit_cnt = 4'h0;
                        if (q.shift[14]) begin
                            d.sdo_sh = reg_read({q.shift[13:0], q.sdi_s}, q);
                            d.sdo = d.sdo_sh[7];
                            d.sdo_sh = d.sdo_sh << 1;
                            d.sdo_oe = 1'b1;
                        end
                    end
                end
                scs_pkg::PH_DATA: begin
                    d.bit_cnt = {1'b0, q.bit_cnt[2:0] + 3'h1};
                    if (byte_done) begin
                        d.got_data = 1'b1;
                        if (q.is_read) begin
                            // [R01] [R02] [R14] [R15] address step
                            {d.loop_cnt, d.addr} = step(q.addr, q.start_addr, q.loop_cnt,
                                q.loop_len, address_direction_up, one_shot_access_mode);
                            d.sdo_sh = reg_read(d.addr, q);
                            d.sdo = d.sdo_sh[7];
                            d.sdo_sh = d.sdo_sh << 1;
                        end else if (q.crc_active) begin
                            d.held_byte = rx_byte;
                            d.phase = scs_pkg::PH_CRC;
                        end else begin
                            d.pend = '{addr: q.addr, data: rx_byte};
                            d.pend_v = 1'b1;
                            // [R01] [R02] [R14] [R15] address step
                            {d.loop_cnt, d.addr} = step(q.addr, q.start_addr, q.loop_cnt,
                                q.loop_len, address_direction_up, one_shot_access_mode);
                        end
                    end
                end
                scs_pkg::PH_CRC: begin
                    d.bit_cnt = {1'b0, q.bit_cnt[2:0] + 3'h1};
                    if (byte_done) begin
                        d.phase = scs_pkg::PH_DATA;
                        if (crc8(q.held_byte) == rx_byte) begin
                            d.pend = '{addr: q.addr, data: q.held_byte};
                            d.pend_v = 1'b1;
                            {d.loop_cnt, d.addr} = step(q.addr, q.start_addr, q.loop_cnt,
                                q.loop_len, address_direction_up, one_shot_access_mode);
                        end else begin
                            // [R10] mismatch drops the byte
                            set_v[scs_pkg::BIT_CRC_ERR] = 1'b1;
                        end
                    end
                end
                default: begin
                end
            endcase
        end else if (fall && q.is_read && q.phase == scs_pkg::PH_DATA
                && q.bit_cnt[2:0] != 3'h0) begin
            d.sdo = q.sdo_sh[7];
            d.sdo_sh = q.sdo_sh << 1;
        end
        // [R07] hardware set wins over clear
        d.errs = d.errs | set_v;
    end

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            q <= '0;
            q.sclk_m <= 1'b0;
            q.sel_m <= 1'b1;
            q.sel_s <= 1'b1;
            q.sel_p <= 1'b1;
            q.phase <= scs_pkg::PH_IDLE;
            q.loop_len <= scs_pkg::RST_LOOP_LEN;
            q.xfer <= scs_pkg::RST_XFER_CTRL;
            q.cfg3 <= scs_pkg::RST_LINK_CFG3;
            q.errs <= scs_pkg::RST_ERR_FLAGS;
            // [R13] channels start powered down
            q.chan <= scs_pkg::RST_CHAN_MODE;
            q.pd <= 4'hF;
        end else begin
            q <= d;
        end
    end

    assign sdo = q.sdo;
    assign sdo_oe = q.sdo_oe;
    assign channel_output_mode = q.chan;
    assign channel_power_down = q.pd;
    assign checksum_active = q.crc_active;
    assign init_done = q.ready;

    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (rst);

    a_crc_pair_gate: assert property (1 |=> (q.crc_active == $past(cfg_ok))) // [R04]
        else $error("checksum enable does not follow field pair");
    a_crcb_reset_off: assert property ($fell(rst) |-> // [R05]
        q.cfg3[scs_pkg::CRCB_HI:scs_pkg::CRCB_LO] == scs_pkg::CRCB_OFF && !q.crc_active)
        else $error("inverted checksum field not off after reset");
    a_strict_fixed_one: assert property (q.cfg3[scs_pkg::BIT_STRICT]) // [R06]
        else $error("strict access bit not one");
    a_mode_reads_zero: assert property (q.cfg3[scs_pkg::MODE_HI:scs_pkg::MODE_LO] == 2'h0) // [R12]
        else $error("active mode field not zero");
    a_not_ready_set: assert property (sel_fall && !q.ready |=> // [R08]
        q.errs[scs_pkg::BIT_NOT_READY] && q.phase == scs_pkg::PH_SKIP)
        else $error("early frame did not set not-ready flag");
    a_clk_count_set: assert property (sel_rise && q.phase == scs_pkg::PH_INSTR |=> // [R09]
        q.errs[scs_pkg::BIT_CLK_CNT])
        else $error("short instruction did not set clock count flag");
    a_flag_set_wins: assert property (set_v != 8'h00 |=> ((q.errs & $past(set_v)) // [R07]
        == $past(set_v)))
        else $error("error flag set was lost");
    a_loop_cnt_clear: assert property (sel_rise && !q.xfer[scs_pkg::BIT_HOLD_LOOP] |=> // [R03]
        q.loop_cnt == 8'h00)
        else $error("loop counter not cleared at select rise");
    a_loop_cnt_hold: assert property (sel_rise && q.xfer[scs_pkg::BIT_HOLD_LOOP] |=> // [R03]
        $stable(q.loop_cnt))
        else $error("held loop counter changed at select rise");
    a_loop_wraps_start: assert property (step_wrap |=> // [R01]
        (q.addr == q.start_addr) && (q.loop_cnt == 8'h00))
        else $error("address did not return to start after loop");
    a_power_down_map: assert property (##1 (q.pd[0] == // [R16]
        ($past(q.chan[1:0]) != scs_pkg::CHAN_NORMAL)))
        else $error("channel power-down decode wrong");

    c_checksum_write: cover property (byte_done && q.phase == scs_pkg::PH_CRC);
    c_stream_read: cover property (byte_done && q.is_read ##1 rise[*1]);
    c_loop_wrap: cover property (step_wrap);
    c_buffer_stall: cover property (q.pend_v && !buf_in_ready);

endmodule : scs_regs_top

// file: verification/scs_host_model.sv
// Host side of the serial link: frames bits onto sclk, select_n and sdi.
// Assumes the system clock paces every pin change; one sclk period is 25 cycles.
`timescale 1ns/1ps
module scs_host_model (
    input wire logic clk_sys,
    output logic sclk,
    output logic select_n,
    output logic sdi,
    input wire logic sdo
);
    initial begin
        sclk = 1'b0;
        select_n = 1'b1;
        sdi = 1'b0;
    end

    // Sends n bits MSB first from the top of bits; rx gathers sdo before each rise
    task automatic frame(input logic [63:0] bits, input int n, output logic [63:0] rx);
        rx = '0;
        @(posedge clk_sys) select_n <= 1'b0;
        repeat (12) @(posedge clk_sys);
        for (int i = 0; i < n; i++) begin
            @(posedge clk_sys) sdi <= bits[63-i];
            repeat (11) @(posedge clk_sys);
            @(negedge clk_sys) rx = {rx[62:0], sdo};
            @(posedge clk_sys) sclk <= 1'b1;
            repeat (12) @(posedge clk_sys);
            sclk <= 1'b0;
        end
        repeat (12) @(posedge clk_sys);
        select_n <= 1'b1;
        // Released data line must not keep its last value
        sdi <= ~sdi;
        repeat (30) @(posedge clk_sys);
    endtask : frame
endmodule : scs_host_model

// file: verification/tb_top.sv
// Self-checking bench for the serial-link register block.
// Assumes scs_host_model drives the link pins; init shortened to 60 cycles.
`timescale 1ns/1ps
module tb_top;
    logic clk_sys;
    logic rst;
    logic dir_up;
    logic one_shot;
    logic sclk;
    logic select_n;
    logic sdi;
    logic sdo;
    logic sdo_oe;
    logic sdo_line;
    int oe_cycles = 0;
    logic checksum_active;
    logic init_done;
    logic [7:0] chan_mode;
    logic [3:0] chan_pd;
    logic [63:0] rx;
    int mismatches = 0;
    int check_count = 0;

    scs_regs_top #(.INIT_CYCLES(60)) dut (
        .clk_sys(clk_sys),
        .rst(rst),
        .sclk(sclk),
        .select_n(select_n),
        .sdi(sdi),
        .address_direction_up(dir_up),
        .one_shot_access_mode(one_shot),
        .sdo(sdo),
        .sdo_oe(sdo_oe),
        .channel_output_mode(chan_mode),
        .channel_power_down(chan_pd),
        .checksum_active(checksum_active),
        .init_done(init_done)
    );

    scs_host_model host (
        .clk_sys(clk_sys),
        .sclk(sclk),
        .select_n(select_n),
        .sdi(sdi),
        .sdo(sdo_line)
    );

    initial begin
        clk_sys = 1'b0;
        forever #2.5 clk_sys = ~clk_sys;
    end

    // Undriven data line shows the inverse of the last bit
    assign sdo_line = sdo_oe ? sdo : ~sdo;

    always @(posedge clk_sys) begin
        if (sdo_oe) begin
            oe_cycles <= oe_cycles + 1;
        end
    end

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        check_count++;
        if (seen !== exp) begin
            mismatches++;
            $display("unexpected at %0t: saw %h, wanted %h", $time, seen, exp);
        end
    endtask : check

    function automatic logic [7:0] crc8(input logic [7:0] d);
        logic [7:0] c;
        c = d;
        for (int i = 0; i < 8; i++) begin
            c = c[7] ? ({c[6:0], 1'b0} ^ 8'h07) : {c[6:0], 1'b0};
        end
        return c;
    endfunction : crc8

    // Single-byte write; cs appends the check byte, bad spoils it
    task automatic wr(input logic [14:0] a, input logic [7:0] d, input logic cs = 1'b0,
                      input logic bad = 1'b0);
        host.frame({1'b0, a, d, crc8(d) ^ {7'h00, bad}, 32'h0}, cs ? 32 : 24, rx);
    endtask : wr

    task automatic rd(input logic [14:0] a, input int n, input logic [31:0] exp);
        int oe0;
        oe0 = oe_cycles;
        host.frame({1'b1, a, 48'h0}, 16 + 8 * n, rx);
        check(rx[31:0] & (32'hFFFF_FFFF >> (32 - 8 * n)), exp);
        check(sdo_oe, 32'h0);
        check((oe_cycles - oe0) > 200 * n, 32'h1);
    endtask : rd

    task automatic wrap_up;
        $display("checks %0d mismatches %0d", check_count, mismatches);
        if (mismatches == 0 && check_count > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask : wrap_up

    initial begin
        #300000;
        mismatches++;
        wrap_up;
    end

    initial begin
        rst = 1'b1;
        dir_up = 1'b1;
        one_shot = 1'b0;
        repeat (12) @(posedge clk_sys);
        rst <= 1'b0;
        @(posedge clk_sys);
        check(init_done, 32'h0);
        host.frame({1'b1, 15'h0020, 48'h0}, 24, rx);
        check(init_done, 32'h1);
        check(chan_mode, 32'hFF);
        check(chan_pd, 32'hF);
        check(checksum_active, 32'h0);
        rd(15'h0011, 1, 32'h80);
        wr(15'h0011, 8'h00);
        rd(15'h0011, 1, 32'h80);
        wr(15'h0011, 8'h80);
        rd(15'h000E, 4, 32'h0000_2300);
        rd(15'h0020, 1, 32'hFF);
        wr(15'h0010, 8'h1F);
        rd(15'h0010, 1, 32'h23);
        // Ends inside the instruction
        host.frame({1'b0, 15'h000A, 48'h0}, 8, rx);
        rd(15'h0011, 1, 32'h10);
        // Ends mid-byte, then an instruction with no data byte
        host.frame({1'b0, 15'h000A, 48'h0}, 20, rx);
        host.frame({1'b0, 15'h000A, 48'h0}, 16, rx);
        rd(15'h0011, 1, 32'h12);
        wr(15'h0011, 8'h02);
        rd(15'h0011, 1, 32'h10);
        wr(15'h0011, 8'h10);
        dir_up <= 1'b0;
        rd(15'h0011, 3, 32'h0000_2300);
        dir_up <= 1'b1;
        one_shot <= 1'b1;
        rd(15'h0010, 2, 32'h0000_2323);
        one_shot <= 1'b0;
        rd(15'h0010, 3, 32'h0023_0000);
        wr(15'h000E, 8'h02);
        rd(15'h000F, 3, 32'h0000_2300);
        wr(15'h000F, 8'h04);
        rd(15'h000F, 2, 32'h0000_0404);
        wr(15'h000F, 8'h00);
        wr(15'h000E, 8'h00);
        wr(15'h0010, 8'h41);
        check(checksum_active, 32'h0);
        rd(15'h0010, 1, 32'h61);
        // enable field and its inverse together
        wr(15'h0010, 8'h62);
        check(checksum_active, 32'h1);
        wr(15'h0020, 8'h00, 1'b1, 1'b1);
        check(chan_mode, 32'hFF);
        rd(15'h0011, 1, 32'h08);
        wr(15'h0020, 8'h1B, 1'b1);
        check(chan_mode, 32'h1B);
        check(chan_pd, 32'h7);
        wr(15'h0011, 8'h08, 1'b1);
        wr(15'h000A, 8'h00);
        rd(15'h0011, 1, 32'h08);
        wr(15'h0010, 8'h03, 1'b1);
        check(checksum_active, 32'h0);
        wr(15'h0011, 8'h08);
        rd(15'h0011, 1, 32'h00);
        wrap_up;
    end
endmodule : tb_top
